// ===== src/bbs_pkg.sv
package bbs_pkg;
    localparam int CLK_NS = 20;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // Times in ns, as printed
    localparam int ADDR_HOLD_NS   = 10;
    localparam int DATA_SETUP_NS  = 50;
    localparam int DATA_HOLD_NS   = 5;
    localparam int STROBE_PULSE_NS = 80;
    localparam int FLOAT_NS       = 50;
    localparam int RECOVERY_NS    = 1000000;
    // Least times round up
    localparam int ADDR_HOLD_CYC  = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_HOLD_CYC  = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC      = (STROBE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC      = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_CYC   = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bbs_req_t;

    typedef struct packed {
        logic              select_low_active_n;
        logic              select_high_active;
        logic              gate_n;
        logic              strobe_n;
        logic [ADDR_W-1:0] addr;
    } bbs_ctl_t;
endpackage

// ===== src/bbs_sync.sv
`timescale 1ns/100ps
module bbs_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Pin in, clean level out
    input  wire logic pin,
    output logic      level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Change counts only when second and third stages agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_r  <= 1'b1;
            s2_r  <= 1'b1;
            s3_r  <= 1'b1;
            level <= 1'b1;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end
endmodule // bbs_sync

// ===== src/bbs_host.sv
`timescale 1ns/100ps
module bbs_host (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Request side
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire bbs_pkg::bbs_req_t     req,
    output logic                       rd_valid,
    output logic [bbs_pkg::DATA_W-1:0] rd_data,
    output logic                       power_ok,
    // Memory pins
    output bbs_pkg::bbs_ctl_t          ctl,
    output logic [bbs_pkg::DATA_W-1:0] data_lines_o,
    output logic                       data_lines_oe,
    input  wire logic [bbs_pkg::DATA_W-1:0] data_lines_i,
    // Open-drain interrupt pin, pulled up outside
    input  wire logic                  pfail_int_n
);
    typedef enum logic [2:0] {
        ST_RECOVER = 3'b000,
        ST_IDLE    = 3'b001,
        ST_SETUP   = 3'b010,
        ST_STROBE  = 3'b011,
        ST_HOLD    = 3'b100,
        ST_READ    = 3'b101,
        ST_GAP     = 3'b110
    } bbs_state_t;

    bbs_state_t                 state_r;
    bbs_state_t                 state_nxt;
    logic [bbs_pkg::CNT_W-1:0]  cnt_r;
    logic [bbs_pkg::CNT_W-1:0]  cnt_nxt;
    logic [bbs_pkg::CNT_W+4:0]  rec_r;
    logic                       int_level;
    logic                       wr_r;
    logic                       rec_done;
    logic                       cnt_zero;
    logic                       accept;
    logic                       sel_active;

    bbs_sync u_int_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin     (pfail_int_n),
        .level   (int_level)
    );

    assign rec_done   = (rec_r == (bbs_pkg::CNT_W+5)'(bbs_pkg::RECOVERY_CYC));
    assign cnt_zero   = (cnt_r == '0);
    assign req_ready  = (state_r == ST_IDLE) && rec_done && int_level;
    assign accept     = req_valid && req_ready;
    assign sel_active = (state_r == ST_STROBE) || (state_r == ST_READ);
    assign power_ok   = rec_done && int_level;

    // --------------------------------------------------------------
    // Recovery timer: restarts whenever the interrupt pin is low
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || !int_level) begin
            rec_r <= '0;
        end else if (!rec_done) begin
            rec_r <= rec_r + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 1'b1;
        case (state_r)
            ST_RECOVER: begin
                if (rec_done && int_level) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!int_level || !rec_done) begin
                    state_nxt = ST_RECOVER;
                end else if (accept) begin
                    state_nxt = ST_SETUP;
                    cnt_nxt   = '0;
                end
            end
            ST_SETUP: begin
                state_nxt = req_r_wr() ? ST_STROBE : ST_READ;
                cnt_nxt   = (bbs_pkg::CNT_W)'(bbs_pkg::PULSE_CYC - 1);
            end
            ST_STROBE: begin
                if (cnt_zero) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = (bbs_pkg::CNT_W)'(bbs_pkg::ADDR_HOLD_CYC);
                end
            end
            ST_READ: begin
                if (cnt_zero) begin
                    state_nxt = ST_GAP;
                    cnt_nxt   = (bbs_pkg::CNT_W)'(bbs_pkg::FLOAT_CYC);
                end
            end
            ST_HOLD, ST_GAP: begin
                if (cnt_zero) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_RECOVER;
        endcase
    end

    function automatic logic req_r_wr();
        return wr_r;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ST_RECOVER;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // --------------------------------------------------------------
    // Pin registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_r          <= 1'b0;
            data_lines_o  <= '0;
            data_lines_oe <= 1'b0;
            rd_valid      <= 1'b0;
            rd_data       <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (accept) begin
                wr_r          <= req.wr;
                data_lines_o  <= req.wdata;
                data_lines_oe <= req.wr;
            end
            if (state_r == ST_HOLD && cnt_zero) begin
                data_lines_oe <= 1'b0;
            end
            if (state_r == ST_READ && cnt_zero) begin
                rd_data  <= data_lines_i;
                rd_valid <= 1'b1;
            end
        end
    end

    // Selects change only with strobe already set, so cycles are
    // strobe-controlled and the address is always stable around them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl.select_low_active_n <= 1'b1;
            ctl.select_high_active  <= 1'b0;
            ctl.gate_n              <= 1'b1;
            ctl.strobe_n            <= 1'b1;
            ctl.addr                <= '0;
        end else begin
            // Address moves only at accept, never inside a cycle
            if (accept) begin
                ctl.addr <= req.addr;
            end
            ctl.select_low_active_n <= !(state_nxt == ST_STROBE
                                       || state_nxt == ST_READ
                                       || state_nxt == ST_SETUP
                                       || state_nxt == ST_HOLD);
            ctl.select_high_active  <= (state_nxt == ST_STROBE
                                       || state_nxt == ST_READ
                                       || state_nxt == ST_SETUP
                                       || state_nxt == ST_HOLD);
            ctl.strobe_n <= !(state_nxt == ST_STROBE);
            ctl.gate_n   <= !(state_nxt == ST_READ);
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    strobe_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ctl.strobe_n |-> ctl.gate_n)
        else $error("gate low during write");
    addr_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ctl.strobe_n |-> $stable(ctl.addr))
        else $error("address moved during write");
    data_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(ctl.strobe_n) |-> data_lines_oe)
        else $error("data dropped at write end");
    pulse_len_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(ctl.strobe_n) |-> !ctl.strobe_n [*4])
        else $error("write strobe too short");
    gap_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(ctl.strobe_n) |=> ctl.strobe_n)
        else $error("no gap after write");
    fail_block_a: assert property (@(posedge clk_sys) disable iff (reset)
        !int_level |=> !req_ready)
        else $error("accepted during power fail");
    sel_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ctl.strobe_n |-> !ctl.select_low_active_n
                          && ctl.select_high_active)
        else $error("strobe without selects");
    power_up_a: assert property (@(posedge clk_sys) disable iff (reset)
        !rec_done |-> !$fell(ctl.select_low_active_n))
        else $error("selected before recovery");
    write_data_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ctl.strobe_n |-> data_lines_oe && $stable(data_lines_o))
        else $error("write data not steady");
    read_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ctl.gate_n |-> !data_lines_oe)
        else $error("host drives during read");
    addr_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(ctl.strobe_n) |=> $stable(ctl.addr))
        else $error("address moved after write");
    start_ok_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_SETUP |-> $past(power_ok))
        else $error("access started without power");
    recover_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_RECOVER |-> ctl.select_low_active_n
                                  && !ctl.select_high_active)
        else $error("selects active in recovery");
endmodule // bbs_host

// ===== sim/bbs_mem_model.sv
`timescale 1ns/100ps
module bbs_mem_model #(
    parameter int DESEL_NS = 20000
) (
    // Host side pins
    input  wire bbs_pkg::bbs_ctl_t ctl,
    input  wire logic [7:0]        bus,
    // Supply stand-in
    input  wire logic              supply_low,
    // Device outputs
    output logic [7:0]             q,
    output logic                   q_oe,
    output logic                   int_low,
    output logic [7:0]             viol
);
    // ----
    // Array and select decode
    // ----
    logic [7:0] mem [0:8191];
    logic       desel;
    logic       sel;
    logic       wr_on;
    logic       wr_prev;
    realtime    t_data;
    realtime    t_end;
    assign sel = !ctl.select_low_active_n && ctl.select_high_active
                 && !desel;
    assign wr_on = sel && !ctl.strobe_n;
    assign q_oe = sel && !ctl.gate_n && ctl.strobe_n;
    assign q = mem[ctl.addr];
    assign int_low = supply_low;
    initial begin
        viol = 8'h00;
        desel = 1'b0;
        wr_prev = 1'b0;
        t_data = 0;
        t_end = -100;
    end
    // Deselect lags the interrupt; protection outlasts the supply dip
    always @(posedge supply_low) #(DESEL_NS) desel = supply_low;
    always @(negedge supply_low) #(1000) desel = 1'b0;
    // Byte lands at write end; only that location may suffer
    always @(wr_on) begin
        if (wr_on === 1'b1 && (!ctl.gate_n || $realtime - t_end < 10))
            viol = viol + 8'h01;
        if (wr_on === 1'b0 && wr_prev === 1'b1) begin
            if ($realtime - t_data < 50)
                viol = viol + 8'h01;
            mem[ctl.addr] = bus;
            t_end = $realtime;
        end
        wr_prev = wr_on;
    end
    always @(ctl.addr) if (wr_on === 1'b1) viol = viol + 8'h01;
    always @(bus) begin
        if ($realtime - t_end < 5)
            viol = viol + 8'h01;
        t_data = $realtime;
    end
endmodule // bbs_mem_model

// ===== sim/test_battery_backed_sram_write_powerfail.sv
`timescale 1ns/100ps
module test_battery_backed_sram_write_powerfail;
    logic              clk_sys, reset, req_valid, req_ready;
    logic              rd_valid, power_ok, host_oe, mem_oe;
    logic              int_low, supply_low, pfail_int_n;
    bbs_pkg::bbs_req_t req;
    bbs_pkg::bbs_ctl_t ctl;
    logic [7:0]        rd_data, host_o, mem_q, fill, data_bus, viol;
    logic [7:0]        shadow [0:8191];
    logic [7:0]        exp_q [$];
    logic [12:0]       a [0:7];
    int                errors, samples_checked, n;
    // ----
    // Pins, pull-up, idle bus pattern
    // ----
    assign pfail_int_n = int_low ? 1'b0 : 1'b1;
    assign data_bus = mem_oe ? mem_q : (host_oe ? host_o : fill);
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) fill <= fill + 8'h3B;
    bbs_host DUT (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
        .rd_data(rd_data), .power_ok(power_ok), .ctl(ctl),
        .data_lines_o(host_o), .data_lines_oe(host_oe),
        .data_lines_i(data_bus), .pfail_int_n(pfail_int_n));
    bbs_mem_model mem (.ctl(ctl), .bus(data_bus), .supply_low(supply_low),
        .q(mem_q), .q_oe(mem_oe), .int_low(int_low), .viol(viol));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic access(logic wr, logic [12:0] ad, logic [7:0] d);
        int k;
        k = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req = '{wr: wr, addr: ad, wdata: d};
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 100)
            errors++;
        if (wr)
            shadow[ad] = d;
        else
            exp_q.push_back(shadow[ad]);
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask
    // Results are checked against notes in issue order
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1 && exp_q.size() == 0)
            check("extra read", 16'h0001, 16'h0000);
        else if (rd_valid === 1'b1)
            check("read data", {8'h00, rd_data},
                  {8'h00, exp_q.pop_front()});
        if (mem_oe && host_oe)
            check("bus clash", 16'h0001, 16'h0000);
    end
    initial begin
        #(bbs_pkg::RECOVERY_NS * 2);
        errors++;
        end_of_test();
    end
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        supply_low = 1'b0;
        fill = 8'h00;
        n = $urandom(32'h661B21A7);
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check("ready early", {15'h0, req_ready}, 16'h0000);
        check("idle select", {15'h0, ctl.select_low_active_n}, 16'h0001);
        repeat (bbs_pkg::RECOVERY_CYC - 20) @(negedge clk_sys);
        check("power ok early", {15'h0, power_ok}, 16'h0000);
        for (n = 0; n < 8; n++) begin
            a[n] = (n == 0) ? 13'h0000 : (n == 1) ? 13'h1FFF : 13'($urandom);
            access(1'b1, a[n], 8'($urandom));
        end
        check("power ok", {15'h0, power_ok}, 16'h0001);
        access(1'b1, a[2], ~shadow[a[2]]);
        for (n = 0; n < 8; n++)
            access(1'b0, a[n], 8'h00);
        n = 0;
        while (exp_q.size() != 0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        check("reads left", 16'(exp_q.size()), 16'h0000);
        supply_low = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("ready in fail", {15'h0, req_ready}, 16'h0000);
        repeat (1100) @(negedge clk_sys);
        check("float in fail", {15'h0, mem_oe}, 16'h0000);
        supply_low = 1'b0;
        repeat (100) @(negedge clk_sys);
        check("power ok rise", {15'h0, power_ok}, 16'h0000);
        check("host timing", {8'h00, viol}, 16'h0000);
        end_of_test();
    end
endmodule // test_battery_backed_sram_write_powerfail
